/* adc_seq_pkg.sv */
// package: register map, field layout and timing of the converter sequencer
// Functional notes
// R01: reference enable, wait 3 us, then start
// R02: fixed mode converts the one chosen input
// R03: scan mode walks inputs upward from 0 or 4
// R04: reset selects input 0, fixed mode
// R05: software bit or trigger falling edge starts; busy set
// R06: software start mid-conversion restarts the sequence
// R07: trigger edges ignored while busy
// R08: repeat and scan bits pick the mode
// R09: single modes end with flag, idle, interrupt
// R10: fixed repeat interrupts every one or four
// R11: scan repeat interrupts after each full scan
// R12: clearing repeat stops after current conversion
// R13: halt stops at once; repeat restarts afterward
// R14: one conversion takes 84 states
// R15: fixed repeat rotates through four result pairs
// R16: otherwise inputs n and n+4 share pair n
// R17: storage flag set on store, cleared on read
// R18: reading a result clears the end flag
// R19: result pairs are read only
// R20: 10-bit result split clear of flag bit
`default_nettype none

package adc_seq_pkg;
	localparam int unsigned ADDR_W      = 8;
	localparam int unsigned DATA_W      = 32;
	localparam int unsigned RES_W       = 10;
	localparam int unsigned NUM_PAIRS   = 4;

	// register byte offsets
	localparam logic [7:0] OFF_MODE0    = 8'h00;
	localparam logic [7:0] OFF_MODE1    = 8'h04;
	localparam logic [7:0] OFF_RES_BASE = 8'h20;
	// result block: pair in addr[4:3], upper half when addr[2] is set
	localparam int unsigned RES_SEL_BIT = 5;
	localparam int unsigned PAIR_LSB    = 3;
	localparam int unsigned HALF_BIT    = 2;

	// conv_mode_reg0 fields
	localparam int unsigned M0_START    = 0;
	localparam int unsigned M0_SCAN     = 1;
	localparam int unsigned M0_REPEAT   = 2;
	localparam int unsigned M0_INTERVAL = 3;
	localparam int unsigned M0_BUSY     = 6;
	localparam int unsigned M0_END      = 7;
	// conv_mode_reg1 fields
	localparam int unsigned M1_CHAN_LSB = 0;
	localparam int unsigned M1_TRIG_EN  = 5;
	localparam int unsigned M1_REF_ON   = 7;
	// lower result register: flag in bit 0, low result bits on top
	localparam int unsigned RL_FLAG     = 0;
	localparam int unsigned RL_DATA_LSB = 6;

	// reset values
	localparam logic [2:0] CHAN_RST     = 3'h0;
	localparam logic       SCAN_RST     = 1'b0;

	// one conversion in system states (one state per clock)
	localparam int unsigned CONV_CYCLES = 84;
	// fixed repeat with interval bit set: interrupt every fourth
	localparam logic [1:0] IRQ_EVERY_LAST = 2'h3;

	// request to the analog comparator
	typedef struct packed {
		logic [2:0] chan;
		logic       sample;
	} ana_req_s;
endpackage

`default_nettype wire

/* adc_fall_detect.sv */
// module: two-flop synchroniser and falling edge detector for a pin
`default_nettype none

module adc_fall_detect (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin,
	output logic      fall
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
	} fd_s;

	fd_s s_reg;
	fd_s s_next;

	// the first stage feeds only the second; the edge looks at later stages
	always_comb begin
		s_next      = s_reg;
		s_next.meta = pin;
		s_next.sync = s_reg.meta;
		s_next.prev = s_reg.sync;
	end

	// idle high so reset release does not fake an edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= 3'h7;
		end else begin
			s_reg <= s_next;
		end
	end

	assign fall = s_reg.prev & ~s_reg.sync;
endmodule

`default_nettype wire

/* adc_conv_timer.sv */
// module: down counter that times one channel conversion
`default_nettype none

module adc_conv_timer #(
	parameter int unsigned CYCLES = adc_seq_pkg::CONV_CYCLES
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic start,
	input  wire logic abort,
	output logic      done
);
	localparam int unsigned CW = $clog2(CYCLES + 1);

	typedef struct packed {
		logic          run;
		logic [CW-1:0] cnt;
	} tm_s;

	tm_s s_reg;
	tm_s s_next;

	// start wins over abort so a restart is never swallowed
	always_comb begin
		s_next = s_reg;
		if (start) begin
			s_next.run = 1'b1;
			s_next.cnt = CW'(CYCLES - 1); // see R14
		end else if (abort || done) begin
			s_next.run = 1'b0;
		end else if (s_reg.run) begin
			s_next.cnt = s_reg.cnt - 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// abort is already folded into the caller's priority; keeping it out avoids a loop
	assign done = s_reg.run && (s_reg.cnt == '0);
endmodule

`default_nettype wire

/* adc_sequencer_control.sv */
// module: converter sequencer with mode control, result store and apb slave
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`default_nettype none

module adc_sequencer_control #(
	parameter int unsigned CONV_CYCLES = adc_seq_pkg::CONV_CYCLES
) (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    ext_trig_n,
	input  wire logic                    halt_light,
	input  wire logic                    halt_deep,
	input  wire logic [9:0]              ana_result,
	output var adc_seq_pkg::ana_req_s    ana_req,
	output logic                         ref_switch_on,
	output logic                         conv_busy_flag,
	output logic                         conv_end_flag,
	output logic                         conv_end_irq
);
	// counter widths below assume a sane conversion length
	if (CONV_CYCLES < 2 || CONV_CYCLES > 4096) begin : g_bad_cycles
		$error("CONV_CYCLES out of range");
	end

	typedef enum logic [1:0] {
		S_IDLE,
		S_CONV,
		S_HALT
	} seq_state_e;

	typedef struct packed {
		seq_state_e                 st;
		logic                       scan;
		logic                       rep;
		logic                       interval;
		logic                       trig_en;
		logic                       ref_on;
		logic [2:0]                 chan_sel;
		logic                       busy;
		logic                       endf;
		logic [2:0]                 cur;
		logic [1:0]                 ring;
		logic [1:0]                 icnt;
		logic                       seq_rep;
		logic                       halt_rep;
		logic [3:0]                 stored;
		logic [3:0][9:0]            res;
		logic [31:0]                rdata;
		logic                       irq;
		logic                       smp;
	} st_s;

	st_s s_reg;
	st_s s_next;

	localparam int unsigned RES_SEL_BIT = adc_seq_pkg::RES_SEL_BIT;
	localparam int unsigned PAIR_LSB    = adc_seq_pkg::PAIR_LSB;
	localparam int unsigned HALF_BIT    = adc_seq_pkg::HALF_BIT;

	logic       trig_fall;
	logic       t_start;
	logic       t_abort;
	logic       t_done;
	logic       acc_wr;
	logic       acc_rd;
	logic       setup;
	logic       sw_start;
	logic       halted;
	logic       last;
	logic [1:0] slot;

	// first input of the selected sequence
	function automatic logic [2:0] seq_first(input logic scan, input logic [2:0] ch);
		seq_first = scan ? {ch[2], 2'b00} : ch; // see R02 see R03
	endfunction

	// address falls inside the result block
	function automatic logic is_result(input logic [7:0] a);
		is_result = (a[7:RES_SEL_BIT] == adc_seq_pkg::OFF_RES_BASE[7:RES_SEL_BIT])
			&& (a[1:0] == 2'b00);
	endfunction

	// any register at this address
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == adc_seq_pkg::OFF_MODE0) || (a == adc_seq_pkg::OFF_MODE1)
			|| is_result(a);
	endfunction

	// begin a sequence from its first input, abandoning any running one
	function automatic st_s begin_seq(input st_s x);
		st_s y;
		y         = x;
		y.st      = S_CONV;
		y.busy    = 1'b1; // see R05
		y.cur     = seq_first(x.scan, x.chan_sel); // see R06
		y.ring    = 2'h0; // see R15
		y.icnt    = 2'h0;
		y.seq_rep = x.rep; // see R08
		y.smp     = 1'b1;
		begin_seq = y;
	endfunction

	// read data for an address, captured in the setup cycle
	function automatic logic [31:0] read_mux(input st_s x, input logic [7:0] a);
		logic [31:0] d;
		logic [1:0]  p;
		d = '0;
		p = a[PAIR_LSB +: 2];
		if (a == adc_seq_pkg::OFF_MODE0) begin
			d[adc_seq_pkg::M0_SCAN]     = x.scan;
			d[adc_seq_pkg::M0_REPEAT]   = x.rep;
			d[adc_seq_pkg::M0_INTERVAL] = x.interval;
			d[adc_seq_pkg::M0_BUSY]     = x.busy;
			d[adc_seq_pkg::M0_END]      = x.endf;
		end else if (a == adc_seq_pkg::OFF_MODE1) begin
			d[adc_seq_pkg::M1_CHAN_LSB +: 3] = x.chan_sel;
			d[adc_seq_pkg::M1_TRIG_EN]       = x.trig_en;
			d[adc_seq_pkg::M1_REF_ON]        = x.ref_on;
		end else if (is_result(a) && a[HALF_BIT]) begin
			d[7:0] = x.res[p][9:2]; // see R20
		end else if (is_result(a)) begin
			d[adc_seq_pkg::RL_DATA_LSB +: 2] = x.res[p][1:0]; // see R20
			d[adc_seq_pkg::RL_FLAG]          = x.stored[p]; // see R17
		end
		read_mux = d;
	endfunction

	adc_fall_detect u_trig (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (ext_trig_n),
		.fall    (trig_fall)
	);

	adc_conv_timer #(
		.CYCLES (CONV_CYCLES)
	) u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (t_start),
		.abort   (t_abort),
		.done    (t_done)
	);

	// bus phases; the slave answers in the first access cycle
	always_comb begin
		setup  = psel & ~penable;
		acc_wr = psel & penable & pwrite;
		acc_rd = psel & penable & ~pwrite;
	end

	// next state: register writes, read side effects, sequencing
	always_comb begin
		s_next   = s_reg;
		s_next.irq = 1'b0;
		s_next.smp = 1'b0;
		t_start  = 1'b0;
		t_abort  = 1'b0;
		sw_start = 1'b0;
		halted   = halt_light | halt_deep;
		slot     = 2'h0;
		last     = 1'b0;

		// control writes; result pairs take no writes
		if (acc_wr && paddr == adc_seq_pkg::OFF_MODE0) begin // see R19
			s_next.scan     = pwdata[adc_seq_pkg::M0_SCAN];
			s_next.rep      = pwdata[adc_seq_pkg::M0_REPEAT]; // see R12
			s_next.interval = pwdata[adc_seq_pkg::M0_INTERVAL];
			sw_start        = pwdata[adc_seq_pkg::M0_START];
		end
		if (acc_wr && paddr == adc_seq_pkg::OFF_MODE1) begin
			s_next.chan_sel = pwdata[adc_seq_pkg::M1_CHAN_LSB +: 3];
			s_next.trig_en  = pwdata[adc_seq_pkg::M1_TRIG_EN];
			s_next.ref_on   = pwdata[adc_seq_pkg::M1_REF_ON]; // see R01
		end

		// read clears first, so a store in the same cycle wins
		if (acc_rd && is_result(paddr)) begin
			s_next.stored[paddr[PAIR_LSB +: 2]] = 1'b0; // see R17
			s_next.endf = 1'b0; // see R18
		end

		// which pair the finishing conversion lands in
		if (s_reg.seq_rep && !s_reg.scan) begin
			slot = s_reg.ring; // see R15
		end else begin
			slot = s_reg.cur[1:0]; // see R16
		end
		last = s_reg.scan ? (s_reg.cur[1:0] == s_reg.chan_sel[1:0]) : 1'b1;

		unique case (s_reg.st)
			S_IDLE, S_CONV: begin
				if (halted) begin
					// stop at once; a single run is simply lost
					t_abort         = 1'b1; // see R13
					s_next.st       = S_HALT;
					s_next.halt_rep = s_reg.busy && s_reg.seq_rep;
					if (!(s_reg.busy && s_reg.seq_rep)) begin
						s_next.busy = 1'b0;
					end
				end else if (sw_start) begin
					s_next  = begin_seq(s_next); // see R05 see R06
					t_start = 1'b1;
				end else if (trig_fall && s_reg.trig_en && !s_reg.busy) begin
					s_next  = begin_seq(s_next); // see R05 see R07
					t_start = 1'b1;
				end else if (s_reg.st == S_CONV && t_done) begin
					s_next.res[slot]    = ana_result; // see R14
					s_next.stored[slot] = 1'b1; // see R17
					s_next.ring         = s_reg.ring + 2'h1; // see R15
					if (last) begin
						s_next.endf = 1'b1; // see R09 see R10 see R11
						if (s_reg.seq_rep && !s_reg.scan && s_reg.interval) begin
							s_next.icnt = s_reg.icnt + 2'h1;
							s_next.irq  = (s_reg.icnt == adc_seq_pkg::IRQ_EVERY_LAST); // see R10
						end else begin
							s_next.irq = 1'b1; // see R09 see R11
						end
					end
					if (s_reg.seq_rep && s_next.rep) begin
						// repeat modes keep busy and go round again
						t_start    = 1'b1; // see R10 see R11
						s_next.smp = 1'b1;
						s_next.cur = last ? seq_first(s_reg.scan, s_reg.chan_sel)
							: s_reg.cur + 3'h1;
					end else if (!s_reg.seq_rep && !last) begin
						t_start    = 1'b1; // see R03
						s_next.smp = 1'b1;
						s_next.cur = s_reg.cur + 3'h1;
					end else begin
						s_next.st   = S_IDLE; // see R09 see R12
						s_next.busy = 1'b0;
					end
				end
			end
			S_HALT: begin
				if (!halted && s_reg.halt_rep && s_reg.rep) begin
					s_next  = begin_seq(s_next); // see R13
					t_start = 1'b1;
				end else if (!halted) begin
					s_next.st   = S_IDLE; // see R13
					s_next.busy = 1'b0;
				end
			end
		endcase

		// capture read data during setup for the access cycle
		if (setup) begin
			s_next.rdata = read_mux(s_reg, paddr);
		end
	end

	// one register for all state; reset picks input 0, fixed single
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg          <= '0;
			s_reg.st       <= S_IDLE;
			s_reg.scan     <= adc_seq_pkg::SCAN_RST; // see R04
			s_reg.chan_sel <= adc_seq_pkg::CHAN_RST; // see R04
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs come straight from the state register, except pready, tied high, and pslverr, decoded from psel, penable and paddr
	assign prdata         = s_reg.rdata;
	assign pready         = 1'b1;
	assign pslverr        = psel & penable & ~is_mapped(paddr);
	assign ana_req.chan   = s_reg.cur; // see R02 see R03
	assign ana_req.sample = s_reg.smp;
	assign ref_switch_on  = s_reg.ref_on; // see R01
	assign conv_busy_flag = s_reg.busy;
	assign conv_end_flag  = s_reg.endf;
	assign conv_end_irq   = s_reg.irq;
endmodule

`default_nettype wire

/* adc_sequencer_control_sva.sv */
// checker: port-level properties of the converter sequencer
`default_nettype none

module adc_seq_sva #(
	parameter int unsigned CONV_CYCLES = 84
) (
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [7:0]            paddr,
	input wire logic [31:0]           pwdata,
	input wire logic                  pslverr,
	input wire logic                  halt_light,
	input wire logic                  halt_deep,
	input wire adc_seq_pkg::ana_req_s ana_req,
	input wire logic                  ref_switch_on,
	input wire logic                  conv_busy_flag,
	input wire logic                  conv_end_flag,
	input wire logic                  conv_end_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	logic res;
	// access phase and result block decode
	assign acc = psel && penable;
	assign res = acc && paddr[7:5] == 3'h1 && paddr[1:0] == 2'h0;

	start_busy_a: assert property (acc && pwrite && paddr == 8'h00 && pwdata[0]
		&& !halt_light && !halt_deep |=> conv_busy_flag && ana_req.sample)
		else $error("start not followed by busy and sample");
	conv_time_a: assert property (conv_end_irq |-> $past(ana_req.sample, CONV_CYCLES))
		else $error("completion not one conversion time after sample");
	end_flag_a: assert property (conv_end_irq |-> conv_end_flag)
		else $error("irq without end flag");
	irq_pulse_a: assert property (conv_end_irq |=> !conv_end_irq)
		else $error("irq longer than one cycle");
	halt_stop_a: assert property (halt_light || halt_deep |=> !ana_req.sample)
		else $error("sample while halted");
	ref_write_a: assert property (acc && pwrite && paddr == 8'h04
		|=> ref_switch_on == $past(pwdata[7])) else $error("reference switch not written");
	read_clear_a: assert property (res && !pwrite && !conv_busy_flag
		|=> !conv_end_flag || conv_end_irq)
		else $error("end flag kept after result read");
	result_ro_a: assert property (res |-> !pslverr)
		else $error("error on result block access");
endmodule

bind adc_sequencer_control adc_seq_sva #(.CONV_CYCLES(CONV_CYCLES)) u_adc_seq_sva (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .halt_light(halt_light),
	.halt_deep(halt_deep), .ana_req(ana_req), .ref_switch_on(ref_switch_on),
	.conv_busy_flag(conv_busy_flag), .conv_end_flag(conv_end_flag),
	.conv_end_irq(conv_end_irq));

`default_nettype wire

/* tb_adc_sequencer_control.sv */
// testbench: apb-driven checks of the converter sequencer
`default_nettype none

module tb_adc_sequencer_control;
	timeunit 1ns;
	timeprecision 1ps;
	// short conversion keeps the run small yet leaves room for mid-run writes
	localparam int CC = 8;
	logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic                  ext_trig_n, halt_light, halt_deep, ref_switch_on;
	logic                  conv_busy_flag, conv_end_flag, conv_end_irq;
	logic [7:0]            paddr;
	logic [31:0]           pwdata, prdata;
	logic [9:0]            ana_result, r;
	adc_seq_pkg::ana_req_s ana_req;
	int                    n_fail, samples_checked, n_irq, n_samp, cnt, base, len, p;
	logic [64:0]           exp_q[$];
	logic [2:0]            chan_q[$];
	logic [9:0]            hist[$];

	adc_sequencer_control #(.CONV_CYCLES(CC)) u_adc_sequencer_control (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_trig_n(ext_trig_n), .halt_light(halt_light), .halt_deep(halt_deep),
		.ana_result(ana_result), .ana_req(ana_req), .ref_switch_on(ref_switch_on),
		.conv_busy_flag(conv_busy_flag), .conv_end_flag(conv_end_flag),
		.conv_end_irq(conv_end_irq));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("compared %0d mismatched %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// scoreboard: each access and each sample takes the oldest note
	always @(posedge pclk) begin
		logic [64:0] e;
		logic [31:0] v;
		if (psel && penable && pready) begin
			chk({31'h0, exp_q.size() == 0}, 32'h0);
			e = exp_q.pop_front();
			chk({31'h0, pslverr}, {31'h0, e[64]});
			chk(prdata & e[63:32], e[31:0]);
		end
		if (conv_end_irq === 1'b1)
			n_irq++;
		if (ana_req.sample === 1'b1) begin
			n_samp++;
			chk({31'h0, chan_q.size() == 0}, 32'h0);
			chk({29'h0, ana_req.chan}, {29'h0, chan_q.pop_front()});
			// fresh value per conversion so misplaced results show
			v = $urandom;
			ana_result <= v[9:0];
			hist.push_back(v[9:0]);
		end
	end

	// one transfer, then one idle cycle so psel is never reassigned in a step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic [31:0] e, input logic er);
		int n;
		exp_q.push_back({er, m, e});
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			n_fail++;
			give_verdict();
		end
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0, m, e, 1'b0);
	endtask

	task automatic wait_for(input int irqs, input logic busy);
		int n;
		n = 0;
		// look at settled outputs mid-cycle, return on a rising edge for driving
		@(negedge pclk);
		while ((n_irq < irqs || conv_busy_flag !== busy) && n < 3000) begin
			@(negedge pclk);
			n++;
		end
		if (n >= 3000) begin
			n_fail++;
			give_verdict();
		end
		@(posedge pclk);
	endtask

	initial begin
		{presetn, psel, penable, pwrite, halt_light, halt_deep} = 6'h0;
		{paddr, pwdata, ana_result, ext_trig_n} = {8'h0, 32'h0, 10'h0, 1'b1};
		{n_fail, samples_checked, n_irq, n_samp} = {32'h0, 32'h0, 32'h0, 32'h0};
		void'($urandom(32'h7dac9ff9));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h00, 32'hff, 32'h0);
		rd(8'h04, 32'hff, 32'h0);
		apb(1'b0, 8'h10, 32'h0, 32'hffffffff, 32'h0, 1'b1);
		// every channel code in fixed single, then in scan single
		for (int s = 0; s < 2; s++) begin
			for (int c = 0; c < 8; c++) begin
				base = (s == 1) ? (c & 4) : c;
				len = (s == 1) ? (c & 3) + 1 : 1;
				for (int j = 0; j < len; j++)
					chan_q.push_back(3'(base + j));
				cnt = n_irq + 1;
				wr(8'h04, 32'h80 | c);
				wr(8'h00, 32'h1 | (s << 1));
				wait_for(cnt, 1'b0);
				chk(conv_end_flag, 1'b1);
				for (int j = 0; j < len; j++) begin
					p = 8 * ((base + j) % 4);
					r = hist[hist.size() - len + j];
					wr(8'h20 + 8'(p), 32'hffffffff);
					if (s == 0)
						rd(8'h20 + 8'(p), 32'hc1, {24'h0, r[1:0], 6'h1});
					rd(8'h24 + 8'(p), 32'hff, {24'h0, r[9:2]});
					rd(8'h20 + 8'(p), 32'hc1, {24'h0, r[1:0], 6'h0});
				end
				chk(conv_end_flag, 1'b0);
			end
		end
		// fixed repeat, irq every fourth, stopped during the ninth
		for (int j = 0; j < 9; j++)
			chan_q.push_back(3'h5);
		cnt = n_samp;
		wr(8'h04, 32'h85);
		wr(8'h00, 32'h0d);
		wait_for(n_irq + 2, 1'b1);
		wr(8'h00, 32'h08);
		wait_for(n_irq, 1'b0);
		chk(n_samp - cnt, 9);
		for (int q = 0; q < 4; q++) begin
			r = hist[hist.size() - 9 + ((q == 0) ? 8 : q + 4)];
			rd(8'h24 + 8'(8 * q), 32'hff, {24'h0, r[9:2]});
		end
		// trigger start, trigger while busy, software restart
		chan_q = '{3'h2, 3'h2};
		cnt = n_irq + 1;
		wr(8'h04, 32'ha2);
		ext_trig_n <= 1'b0;
		repeat (6) @(posedge pclk);
		ext_trig_n <= 1'b1;
		repeat (2) @(posedge pclk);
		ext_trig_n <= 1'b0;
		wr(8'h00, 32'h1);
		wait_for(cnt, 1'b0);
		repeat (20) @(posedge pclk);
		chk(n_irq, cnt);
		chk(chan_q.size(), 0);
		ext_trig_n <= 1'b1;
		// halt in scan repeat restarts the scan, halt in single stays stopped
		chan_q = '{3'h0, 3'h0, 3'h1, 3'h0, 3'h4};
		wr(8'h04, 32'h81);
		wr(8'h00, 32'h07);
		halt_light <= 1'b1;
		repeat (10) @(posedge pclk);
		halt_light <= 1'b0;
		cnt = n_irq + 1;
		wait_for(cnt, 1'b1);
		wr(8'h00, 32'h02);
		wait_for(cnt, 1'b0);
		wr(8'h04, 32'h84);
		wr(8'h00, 32'h01);
		halt_deep <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(conv_busy_flag, 1'b0);
		halt_deep <= 1'b0;
		repeat (20) @(posedge pclk);
		chk(chan_q.size(), 0);
		give_verdict();
	end
endmodule

`default_nettype wire
